// >>> core/acd_setup_decoder.sv
// setup command decoder with reference wake-up sequencer
`timescale 1ns/1ps
module acd_setup_decoder (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output logic spi_miso_oe_o,
	input wire logic ref_force_on_i,
	input wire logic dac_ref_demand_i,
	input wire logic scan_req_i,
	input wire logic temp_req_i,
	input wire logic scan_done_i,
	input wire logic [15:0] temp_result_i,
	output logic [1:0] clk_mode_o,
	output logic [1:0] ref_mode_o,
	output logic [7:0] unipolar_pairs_o,
	output logic [7:0] bipolar_pairs_o,
	output logic conv_start_is_ain_o,
	output logic start_times_sampling_o,
	output logic serial_conv_clk_o,
	output logic adc_ext_ref_dedicated_o,
	output logic int_ref_on_o,
	output logic ref_always_on_o,
	output logic conv_go_o,
	output logic temp_go_o,
	output logic temp_present_o,
	output logic busy_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_SETTLE, ST_TEMP_DLY} acd_state_t;

	acd_byte_if link ();

	acd_serial_rx u_rx (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.spi_sclk_i(spi_sclk_i),
		.spi_cs_n_i(spi_cs_n_i),
		.spi_mosi_i(spi_mosi_i),
		.bus(link.rx)
	);

	logic [1:0] clk_mode_reg;
	logic [1:0] ref_mode_reg;
	logic [7:0] uni_reg;
	logic [7:0] bi_reg;
	acd_pkg::acd_pair_t expect_reg;
	logic setup_hit;

	// any byte not awaited as pairing data is a fresh command
	assign setup_hit = link.byte_valid && (expect_reg == acd_pkg::PAIR_NONE) &&
		(link.byte_data[acd_pkg::SEL_MSB:acd_pkg::SEL_B6] == acd_pkg::SETUP_SEL); // see [R1] see [R2]

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			clk_mode_reg <= acd_pkg::CLK_MODE_RESET; // see [R4]
			ref_mode_reg <= acd_pkg::REF_MODE_RESET; // see [R13]
		end else if (setup_hit) begin
			clk_mode_reg <= link.byte_data[acd_pkg::CLK_MSB:acd_pkg::CLK_LSB]; // see [R3]
			ref_mode_reg <= link.byte_data[acd_pkg::REF_MSB:acd_pkg::REF_LSB];
		end
	end

	// pairing data must arrive in the same select frame
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !link.frame_active) begin
			expect_reg <= acd_pkg::PAIR_NONE;
		end else if (setup_hit) begin
			if (!link.byte_data[acd_pkg::PAIR_MSB])
				expect_reg <= acd_pkg::PAIR_NONE; // see [R14]
			else if (link.byte_data[acd_pkg::PAIR_LSB])
				expect_reg <= acd_pkg::PAIR_BI;
			else
				expect_reg <= acd_pkg::PAIR_UNI;
		end else if (link.byte_valid) begin
			expect_reg <= acd_pkg::PAIR_NONE; // see [R17]
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			uni_reg <= acd_pkg::PAIR_RESET; // see [R18]
			bi_reg <= acd_pkg::PAIR_RESET;
		end else if (link.byte_valid) begin
			if (expect_reg == acd_pkg::PAIR_UNI)
				uni_reg <= link.byte_data; // see [R15]
			if (expect_reg == acd_pkg::PAIR_BI)
				bi_reg <= link.byte_data; // see [R16]
		end
	end

	// conversion clock: internal divider, or serial clock rises in mode 11
	logic [5:0] div_reg;
	logic int_tick;
	logic conv_tick;
	assign int_tick = (div_reg == 6'(acd_pkg::INT_CONV_DIV - 1));
	assign conv_tick = (clk_mode_reg == acd_pkg::CLK_MODE_SERIAL) ? link.sclk_rise : int_tick; // see [R6] see [R8]

	always_ff @(posedge core_clk_i) begin
		if (reset_i || int_tick)
			div_reg <= 6'h00;
		else
			div_reg <= div_reg + 6'h01;
	end

	logic forced_on;
	logic ext_ref;
	assign forced_on = ref_force_on_i || (dac_ref_demand_i && ref_mode_reg == acd_pkg::REF_MODE_INT_BOTH); // see [R19]
	assign ext_ref = ref_mode_reg[0]; // see [R12]

	acd_state_t state_reg;
	logic [7:0] cnt_reg;
	logic int_ref_reg;
	logic forced_reg;
	logic temp_pend_reg;
	logic go_reg;
	logic tgo_reg;
	logic present_reg;
	logic wait_done;
	assign wait_done = conv_tick && (cnt_reg == 8'h00);

	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			forced_reg <= 1'b0;
		else
			forced_reg <= forced_on;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			temp_pend_reg <= 1'b0;
			go_reg <= 1'b0;
			tgo_reg <= 1'b0;
			present_reg <= 1'b0;
		end else begin
			go_reg <= 1'b0;
			tgo_reg <= 1'b0;
			present_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (scan_req_i && temp_req_i) begin
						temp_pend_reg <= 1'b1;
						if (forced_on) begin
							state_reg <= ST_TEMP_DLY; // see [R11]
							cnt_reg <= acd_pkg::TEMP_DELAY_CYCLES - 8'h01;
						end else if (!int_ref_reg) begin
							state_reg <= ST_SETTLE; // see [R9]
							cnt_reg <= acd_pkg::TEMP_SETTLE_CYCLES - 8'h01;
						end else if (clk_mode_reg == acd_pkg::CLK_MODE_SERIAL) begin
							state_reg <= ST_TEMP_DLY;
							cnt_reg <= acd_pkg::TEMP_DELAY_CYCLES - 8'h01;
						end else begin
							tgo_reg <= 1'b1;
							go_reg <= 1'b1;
							temp_pend_reg <= 1'b0;
						end
					end else if (scan_req_i) begin
						if (!ext_ref && !int_ref_reg && !forced_on) begin
							state_reg <= ST_WAKE; // see [R7]
							cnt_reg <= acd_pkg::AIN_WAKE_CYCLES - 8'h01;
						end else begin
							go_reg <= 1'b1; // see [R12]
						end
					end
				end
				ST_WAKE: begin
					if (wait_done) begin
						state_reg <= ST_IDLE;
						go_reg <= 1'b1;
					end else if (conv_tick) begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				ST_SETTLE: begin
					if (wait_done && clk_mode_reg == acd_pkg::CLK_MODE_SERIAL) begin
						state_reg <= ST_TEMP_DLY; // see [R10]
						cnt_reg <= acd_pkg::TEMP_DELAY_CYCLES - 8'h01;
					end else if (wait_done) begin
						state_reg <= ST_IDLE;
						tgo_reg <= 1'b1;
						go_reg <= 1'b1;
						temp_pend_reg <= 1'b0;
					end else if (conv_tick) begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				ST_TEMP_DLY: begin
					if (wait_done) begin
						state_reg <= ST_IDLE;
						tgo_reg <= 1'b1;
						go_reg <= 1'b1;
						temp_pend_reg <= 1'b0;
						present_reg <= (clk_mode_reg == acd_pkg::CLK_MODE_SERIAL);
					end else if (conv_tick) begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// reference wakes on wake or settle wait entry; auto shutdown after the scan
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			int_ref_reg <= 1'b0;
		else if (forced_on || state_reg == ST_WAKE || state_reg == ST_SETTLE)
			int_ref_reg <= 1'b1;
		else if (scan_done_i)
			int_ref_reg <= 1'b0; // see [R13]
	end

	// temperature word leaves msb first on serial clock falls
	logic [15:0] dout_reg;
	logic oe_reg;
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dout_reg <= 16'h0000;
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= link.frame_active;
			if (present_reg)
				dout_reg <= temp_result_i; // see [R10]
			else if (link.frame_active && link.sclk_fall)
				dout_reg <= {dout_reg[14:0], 1'b0};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			spi_miso_o <= 1'b0;
			spi_miso_oe_o <= 1'b0;
			clk_mode_o <= acd_pkg::CLK_MODE_RESET;
			ref_mode_o <= acd_pkg::REF_MODE_RESET;
			unipolar_pairs_o <= acd_pkg::PAIR_RESET;
			bipolar_pairs_o <= acd_pkg::PAIR_RESET;
			conv_start_is_ain_o <= 1'b1;
			start_times_sampling_o <= 1'b0;
			serial_conv_clk_o <= 1'b0;
			adc_ext_ref_dedicated_o <= 1'b0;
			int_ref_on_o <= 1'b0;
			ref_always_on_o <= 1'b0;
			conv_go_o <= 1'b0;
			temp_go_o <= 1'b0;
			temp_present_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			spi_miso_o <= dout_reg[15];
			spi_miso_oe_o <= oe_reg;
			clk_mode_o <= clk_mode_reg;
			ref_mode_o <= ref_mode_reg;
			unipolar_pairs_o <= uni_reg;
			bipolar_pairs_o <= bi_reg;
			conv_start_is_ain_o <= clk_mode_reg[1]; // see [R3]
			start_times_sampling_o <= (clk_mode_reg == acd_pkg::CLK_MODE_START_TIMED); // see [R5]
			serial_conv_clk_o <= (clk_mode_reg == acd_pkg::CLK_MODE_SERIAL);
			adc_ext_ref_dedicated_o <= ext_ref; // see [R12]
			int_ref_on_o <= int_ref_reg;
			ref_always_on_o <= forced_reg;
			conv_go_o <= go_reg;
			temp_go_o <= tgo_reg;
			temp_present_o <= present_reg;
			busy_o <= (state_reg != ST_IDLE);
		end
	end

	chk_nonsetup_ignored: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R1]
		link.byte_valid && expect_reg == acd_pkg::PAIR_NONE && link.byte_data[7]
		|=> $stable(clk_mode_reg) && $stable(ref_mode_reg))
		else $error("command with bit seven set changed the setup");
	chk_bit6_required: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R2]
		link.byte_valid && expect_reg == acd_pkg::PAIR_NONE && link.byte_data[7:6] == 2'h0
		|=> $stable(ref_mode_reg) && expect_reg == acd_pkg::PAIR_NONE)
		else $error("command with bit six clear acted as setup");
	chk_clk_mode_load: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R3]
		setup_hit |=> clk_mode_reg == $past(link.byte_data[5:4]) ##2 clk_mode_o == $past(clk_mode_reg, 2))
		else $error("clock mode field not loaded from setup byte");
	chk_reset_clk_mode: assert property (@(posedge core_clk_i) // see [R4]
		$fell(reset_i) |-> clk_mode_reg[1] && conv_start_is_ain_o)
		else $error("upper clock mode bit not one after reset");
	chk_no_pair_byte: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R14]
		link.byte_valid && expect_reg == acd_pkg::PAIR_NONE |=> $stable(uni_reg) && $stable(bi_reg))
		else $error("pairing register written without request");
	chk_uni_store: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R15]
		link.byte_valid && expect_reg == acd_pkg::PAIR_UNI
		|=> uni_reg == $past(link.byte_data) && $stable(bi_reg) && expect_reg == acd_pkg::PAIR_NONE)
		else $error("unipolar pairing byte not stored");
	chk_bi_store: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R16]
		link.byte_valid && expect_reg == acd_pkg::PAIR_BI
		|=> bi_reg == $past(link.byte_data) && $stable(uni_reg))
		else $error("bipolar pairing byte not stored");
	chk_wake_start: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R7]
		state_reg == ST_IDLE && scan_req_i && !temp_req_i && !ext_ref && !int_ref_reg && !forced_on
		|=> state_reg == ST_WAKE && cnt_reg == 8'hD9 && !go_reg)
		else $error("input scan did not start the 218 cycle wake wait");
	chk_wake_end: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R8]
		state_reg == ST_WAKE && conv_tick && cnt_reg == 8'h00 |=> go_reg && state_reg == ST_IDLE)
		else $error("wake wait did not end in a conversion start");
	chk_ext_no_wake: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R12]
		state_reg == ST_IDLE && scan_req_i && !temp_req_i && ext_ref |=> go_reg ##1 conv_go_o)
		else $error("external reference scan waited for wake-up");
	chk_forced_delay: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R11]
		state_reg == ST_IDLE && scan_req_i && temp_req_i && forced_on
		|=> state_reg == ST_TEMP_DLY && cnt_reg == 8'hBB)
		else $error("forced reference temperature lacks 188 cycle delay");
	chk_force_on: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R19]
		ref_force_on_i |=> forced_reg && int_ref_reg ##1 ref_always_on_o)
		else $error("force bit did not hold reference on");
	chk_dac_force: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R19]
		dac_ref_demand_i && ref_mode_reg == acd_pkg::REF_MODE_INT_BOTH |=> forced_reg)
		else $error("dac demand in mode 00 did not force reference");
	chk_settle_start: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R9]
		state_reg == ST_IDLE && scan_req_i && temp_req_i && !forced_on && !int_ref_reg
		|=> state_reg == ST_SETTLE && cnt_reg == 8'hF3)
		else $error("temperature did not start the 244 cycle settle wait");
	chk_temp_pending: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R9]
		temp_pend_reg |-> state_reg == ST_SETTLE || state_reg == ST_TEMP_DLY)
		else $error("temperature pending outside its waits");
	chk_temp_go_pair: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R9]
		tgo_reg |-> go_reg)
		else $error("temperature go without conversion go");
	chk_serial_settle_end: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R10]
		state_reg == ST_SETTLE && wait_done && clk_mode_reg == acd_pkg::CLK_MODE_SERIAL
		|=> state_reg == ST_TEMP_DLY && cnt_reg == 8'hBB)
		else $error("serial mode settle did not add the 188 cycle delay");
	chk_present_load: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R10]
		present_reg |=> dout_reg == $past(temp_result_i))
		else $error("temperature word not loaded for data out");
	chk_start_timed: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R5]
		clk_mode_reg == acd_pkg::CLK_MODE_START_TIMED |=> start_times_sampling_o)
		else $error("clock mode 01 did not select start timed sampling");
	chk_serial_tick: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R6]
		clk_mode_reg == acd_pkg::CLK_MODE_SERIAL && state_reg != ST_IDLE && !link.sclk_rise |=> $stable(cnt_reg))
		else $error("serial mode wait counted without a serial clock");
	chk_int_ref_down: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R13]
		scan_done_i && !forced_on && state_reg == ST_IDLE |=> !int_ref_reg)
		else $error("internal reference stayed on after the scan");
	chk_pair_reset: assert property (@(posedge core_clk_i) // see [R18]
		$fell(reset_i) |-> uni_reg == acd_pkg::PAIR_RESET && bi_reg == acd_pkg::PAIR_RESET)
		else $error("pairing registers not zero after reset");
	chk_pair_cancel: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R17]
		!link.frame_active |=> expect_reg == acd_pkg::PAIR_NONE)
		else $error("pairing byte still awaited after deselect");
	chk_ext_dedicated: assert property (@(posedge core_clk_i) disable iff (reset_i) // see [R12]
		ext_ref |=> adc_ext_ref_dedicated_o)
		else $error("external reference mode did not dedicate the pin");
endmodule : acd_setup_decoder

// >>> core/acd_pkg.sv
// constants and types of the setup command decoder
// Operation
// [R1] a command byte is a setup command only when bit seven is zero
// [R2] a setup command also needs bit six set to one
// [R3] bits five and four select clock mode, acquisition timing and start pin use
// [R4] upper clock-mode bit loads one at power-up
// [R5] clock mode 01 converts on internal clock, sampling timed by start pulse
// [R6] clock mode 11 converts and acquires on serial clock, at most 3.6 MHz
// [R7] internal reference sleeps after scans, input scan then waits 218 internal clocks
// [R8] in clock mode 11 that wake wait counts 218 serial clocks
// [R9] temperature always uses internal reference, waits 244 clocks after wake-up
// [R10] in clock mode 11 temperature appears on data out 188 clocks later
// [R11] reference forced on skips wake wait but still delays temperature 188 clocks
// [R12] external reference modes never wake internal reference, second pin is reference; code wakes it for temperature and force bit
// [R13] reference mode 10 is default, internal reference sleeps after each scan
// [R14] low setup bits 00 or 01 mean no data byte, pairing unchanged
// [R15] low setup bits 10 mean next byte goes to unipolar pairing register
// [R16] low setup bits 11 mean next byte goes to bipolar pairing register
// [R17] setup plus data keeps select low sixteen clocks, later bytes are commands
// [R18] both pairing registers reset to all zeros
// [R19] reference forced on by force bit, or DAC demand in reference mode 00
// [R20] bytes arrive most significant bit first, decoded once eight bits are in
package acd_pkg;
	localparam int CORE_CLK_KHZ = 200000;
	localparam int SCLK_MAX_KHZ = 3600;
	// internal conversion clock never runs faster than the external limit
	localparam int INT_CONV_DIV = (CORE_CLK_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
	localparam int BYTE_BITS = 8;
	localparam int SEL_MSB = 7;
	localparam int SEL_B6 = 6;
	localparam int CLK_MSB = 5;
	localparam int CLK_LSB = 4;
	localparam int REF_MSB = 3;
	localparam int REF_LSB = 2;
	localparam int PAIR_MSB = 1;
	localparam int PAIR_LSB = 0;
	localparam logic [1:0] SETUP_SEL = 2'h1;
	localparam logic [1:0] CLK_MODE_RESET = 2'h2;
	localparam logic [1:0] CLK_MODE_START_TIMED = 2'h1;
	localparam logic [1:0] CLK_MODE_SERIAL = 2'h3;
	localparam logic [1:0] REF_MODE_RESET = 2'h2;
	localparam logic [1:0] REF_MODE_INT_BOTH = 2'h0;
	localparam logic [7:0] PAIR_RESET = 8'h00;
	localparam logic [7:0] AIN_WAKE_CYCLES = 8'hDA;
	localparam logic [7:0] TEMP_SETTLE_CYCLES = 8'hF4;
	localparam logic [7:0] TEMP_DELAY_CYCLES = 8'hBC;
	localparam int TEMP_BITS = 16;
	typedef enum logic [1:0] {PAIR_NONE, PAIR_UNI, PAIR_BI} acd_pair_t;
endpackage : acd_pkg

// >>> core/acd_byte_if.sv
// carrier between the serial receiver and the decoder core
`timescale 1ns/1ps
interface acd_byte_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic frame_active;
	logic sclk_rise;
	logic sclk_fall;
	modport rx (output byte_valid, output byte_data, output frame_active, output sclk_rise, output sclk_fall);
	modport core (input byte_valid, input byte_data, input frame_active, input sclk_rise, input sclk_fall);
endinterface : acd_byte_if

// >>> core/acd_serial_rx.sv
// serial byte receiver with pin synchronisers
`timescale 1ns/1ps
module acd_serial_rx (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	acd_byte_if.rx bus
);
	logic [2:0] sclk_sync_reg;
	logic [2:0] cs_sync_reg;
	logic [2:0] mosi_sync_reg;
	logic sclk_reg;
	logic cs_n_reg;
	logic mosi_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg <= 3'h7;
			mosi_sync_reg <= 3'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
			cs_sync_reg <= {cs_sync_reg[1:0], spi_cs_n_i};
			mosi_sync_reg <= {mosi_sync_reg[1:0], spi_mosi_i};
		end
	end

	// a level counts only once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
		end else begin
			if (sclk_sync_reg[1] == sclk_sync_reg[2])
				sclk_reg <= sclk_sync_reg[2];
			if (cs_sync_reg[1] == cs_sync_reg[2])
				cs_n_reg <= cs_sync_reg[2];
			if (mosi_sync_reg[1] == mosi_sync_reg[2])
				mosi_reg <= mosi_sync_reg[2];
		end
	end

	logic rise;
	logic fall;
	assign rise = !sclk_reg && (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2];
	assign fall = sclk_reg && (sclk_sync_reg[1] == sclk_sync_reg[2]) && !sclk_sync_reg[2];

	always_ff @(posedge core_clk_i) begin
		if (reset_i || cs_n_reg) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 7'h00;
			bus.byte_valid <= 1'b0;
			bus.byte_data <= 8'h00;
		end else begin
			bus.byte_valid <= 1'b0;
			if (rise) begin
				shift_reg <= {shift_reg[5:0], mosi_reg}; // see [R20]
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					bus.byte_valid <= 1'b1;
					bus.byte_data <= {shift_reg, mosi_reg};
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus.frame_active <= 1'b0;
			bus.sclk_rise <= 1'b0;
			bus.sclk_fall <= 1'b0;
		end else begin
			bus.frame_active <= !cs_n_reg;
			bus.sclk_rise <= rise;
			bus.sclk_fall <= fall;
		end
	end
endmodule : acd_serial_rx

// >>> testbench/acd_spi_host.sv
// behavioural serial host that clocks command frames into the decoder
`timescale 1ns/1ps
module acd_spi_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// 80 ns serial period, clock idles low outside frames
	// bits beyond the 24 given are zeros, used as ignored filler to keep the clock running
	task automatic send(input logic [23:0] bits, input int n);
		cs_n_o = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = (i < 24) ? bits[i] : 1'b0;
			#40 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
		end
		#40 cs_n_o = 1'b1;
		// released line shows the inverse so stale data cannot pass for valid
		mosi_o = ~mosi_o;
		#40;
	endtask : send
endmodule : acd_spi_host

// >>> testbench/tb_acd_setup_decoder.sv
// self-checking bench of the setup command decoder
`timescale 1ns/1ps
module tb_acd_setup_decoder;
	logic core_clk_i;
	logic reset_i;
	logic spi_sclk, spi_cs_n, spi_mosi;
	logic spi_miso_o, spi_miso_oe_o;
	logic ref_force_on_i, dac_ref_demand_i, scan_req_i, temp_req_i, scan_done_i;
	logic [15:0] temp_result_i;
	logic [1:0] clk_mode_o, ref_mode_o;
	logic [7:0] unipolar_pairs_o, bipolar_pairs_o;
	logic conv_start_is_ain_o, start_times_sampling_o, serial_conv_clk_o, adc_ext_ref_dedicated_o;
	logic int_ref_on_o, ref_always_on_o, conv_go_o, temp_go_o, temp_present_o, busy_o;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	acd_spi_host host (.sclk_o(spi_sclk), .cs_n_o(spi_cs_n), .mosi_o(spi_mosi));

	acd_setup_decoder DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .spi_sclk_i(spi_sclk),
		.spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
		.ref_force_on_i(ref_force_on_i), .dac_ref_demand_i(dac_ref_demand_i), .scan_req_i(scan_req_i),
		.temp_req_i(temp_req_i), .scan_done_i(scan_done_i), .temp_result_i(temp_result_i),
		.clk_mode_o(clk_mode_o), .ref_mode_o(ref_mode_o), .unipolar_pairs_o(unipolar_pairs_o),
		.bipolar_pairs_o(bipolar_pairs_o), .conv_start_is_ain_o(conv_start_is_ain_o),
		.start_times_sampling_o(start_times_sampling_o), .serial_conv_clk_o(serial_conv_clk_o),
		.adc_ext_ref_dedicated_o(adc_ext_ref_dedicated_o), .int_ref_on_o(int_ref_on_o),
		.ref_always_on_o(ref_always_on_o), .conv_go_o(conv_go_o), .temp_go_o(temp_go_o),
		.temp_present_o(temp_present_o), .busy_o(busy_o));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	task automatic give_verdict();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// long waits total about 50k cycles
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic cmp_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_val

	task automatic cmp_range(input string what, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : cmp_range

	// one frame, then time for the synchronisers and the field update
	task automatic wr(input logic [23:0] bits, input int nb);
		host.send(bits, nb);
		repeat (12) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask : wr

	task automatic pulse_done();
		@(posedge core_clk_i);
		scan_done_i <= 1'b1;
		@(posedge core_clk_i);
		scan_done_i <= 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask : pulse_done

	// cycles from request to go pulse, or to temperature presentation
	task automatic measure(input logic t, input logic on_present, output int cnt);
		logic bz;
		@(posedge core_clk_i);
		scan_req_i <= 1'b1;
		temp_req_i <= t;
		@(posedge core_clk_i);
		scan_req_i <= 1'b0;
		@(negedge core_clk_i);
		cnt = 1;
		bz = 1'b0;
		while (!(on_present ? temp_present_o === 1'b1 : conv_go_o === 1'b1) && cnt < 20000) begin
			@(negedge core_clk_i);
			cnt++;
			bz = bz | busy_o;
		end
		cmp_val("temp_go", {7'h00, t}, {7'h00, temp_go_o});
		cmp_val("busy", {7'h00, cnt > 2}, {7'h00, bz});
		cmp_val("idle", 8'h00, {7'h00, busy_o});
		if (on_present) begin
			@(negedge core_clk_i);
			cmp_val("miso", {7'h00, temp_result_i[15]}, {7'h00, spi_miso_o});
			cmp_val("miso_oe", 8'h01, {7'h00, spi_miso_oe_o});
		end
	endtask : measure

	task automatic t_reset();
		cmp_val("clk_mode", 8'h02, {6'h00, clk_mode_o});
		cmp_val("ref_mode", 8'h02, {6'h00, ref_mode_o});
		cmp_val("uni", 8'h00, unipolar_pairs_o);
		cmp_val("bi", 8'h00, bipolar_pairs_o);
		cmp_val("start_ain", 8'h01, {7'h00, conv_start_is_ain_o});
		cmp_val("miso_oe", 8'h00, {7'h00, spi_miso_oe_o});
	endtask : t_reset

	task automatic t_modes();
		logic [1:0] cm;
		for (int i = 0; i < 4; i++) begin
			cm = i[1:0];
			wr({16'h0000, 2'h1, cm, cm, 1'b0, cm[0]}, 8);
			cmp_val("clk_mode", {6'h00, cm}, {6'h00, clk_mode_o});
			cmp_val("ref_mode", {6'h00, cm}, {6'h00, ref_mode_o});
			cmp_val("start_ain", {7'h00, cm[1]}, {7'h00, conv_start_is_ain_o});
			cmp_val("start_timed", {7'h00, cm == 2'h1}, {7'h00, start_times_sampling_o});
			cmp_val("serial_clk", {7'h00, cm == 2'h3}, {7'h00, serial_conv_clk_o});
			cmp_val("ext_ref", {7'h00, cm[0]}, {7'h00, adc_ext_ref_dedicated_o});
			cmp_val("uni", 8'h00, unipolar_pairs_o);
			cmp_val("bi", 8'h00, bipolar_pairs_o);
		end
		// wrong selection patterns must leave mode 11 / ref 11 alone
		wr(24'h0000FF, 8);
		wr(24'h00003F, 8);
		wr(24'h0000B0, 8);
		cmp_val("clk_mode", 8'h03, {6'h00, clk_mode_o});
		cmp_val("ref_mode", 8'h03, {6'h00, ref_mode_o});
	endtask : t_modes

	task automatic t_pairs();
		wr(24'h004AA5, 16);
		cmp_val("uni", 8'hA5, unipolar_pairs_o);
		cmp_val("bi", 8'h00, bipolar_pairs_o);
		wr(24'h004B3C, 16);
		cmp_val("bi", 8'h3C, bipolar_pairs_o);
		cmp_val("uni", 8'hA5, unipolar_pairs_o);
		wr(24'h4A1170, 24);
		cmp_val("uni", 8'h11, unipolar_pairs_o);
		cmp_val("clk_mode", 8'h03, {6'h00, clk_mode_o});
		cmp_val("ref_mode", 8'h00, {6'h00, ref_mode_o});
		// pending data byte dropped at deselect, next frame is a command
		wr(24'h00004B, 8);
		wr(24'h000064, 8);
		cmp_val("bi", 8'h3C, bipolar_pairs_o);
		cmp_val("clk_mode", 8'h02, {6'h00, clk_mode_o});
		cmp_val("ref_mode", 8'h01, {6'h00, ref_mode_o});
	endtask : t_pairs

	task automatic t_reference();
		measure(1'b0, 1'b0, n);
		cmp_range("ext_ref_go", 2, 2, n);
		wr(24'h000068, 8);
		cmp_val("int_ref", 8'h00, {7'h00, int_ref_on_o});
		measure(1'b0, 1'b0, n);
		cmp_range("ain_wake", 218 * 56 - 56, 218 * 56 + 16, n);
		cmp_val("int_ref", 8'h01, {7'h00, int_ref_on_o});
		measure(1'b0, 1'b0, n);
		cmp_range("ref_on_go", 2, 2, n);
		pulse_done();
		cmp_val("int_ref", 8'h00, {7'h00, int_ref_on_o});
		measure(1'b1, 1'b0, n);
		cmp_range("temp_wake", 244 * 56 - 56, 244 * 56 + 16, n);
		pulse_done();
	endtask : t_reference

	task automatic t_forced();
		@(posedge core_clk_i);
		ref_force_on_i <= 1'b1;
		repeat (4) @(negedge core_clk_i);
		cmp_val("always_on", 8'h01, {7'h00, ref_always_on_o});
		measure(1'b1, 1'b0, n);
		cmp_range("forced_temp", 188 * 56 - 56, 188 * 56 + 16, n);
		@(posedge core_clk_i);
		ref_force_on_i <= 1'b0;
		dac_ref_demand_i <= 1'b1;
		repeat (4) @(negedge core_clk_i);
		cmp_val("always_on", 8'h00, {7'h00, ref_always_on_o});
		wr(24'h000060, 8);
		cmp_val("always_on", 8'h01, {7'h00, ref_always_on_o});
		@(posedge core_clk_i);
		dac_ref_demand_i <= 1'b0;
		pulse_done();
	endtask : t_forced

	// serial clock paces the waits: one rise every 16 core cycles
	task automatic t_serial();
		wr(24'h000078, 8);
		pulse_done();
		fork
			measure(1'b0, 1'b0, n);
			host.send(24'h000000, 300);
		join
		cmp_range("serial_ain", 218 * 16 - 16, 218 * 16 + 32, n);
		pulse_done();
		fork
			measure(1'b1, 1'b1, n);
			host.send(24'h000000, 480);
		join
		cmp_range("serial_temp", 432 * 16 - 16, 432 * 16 + 32, n);
	endtask : t_serial

	initial begin
		reset_i = 1'b1;
		ref_force_on_i = 1'b0;
		dac_ref_demand_i = 1'b0;
		scan_req_i = 1'b0;
		temp_req_i = 1'b0;
		scan_done_i = 1'b0;
		temp_result_i = 16'hC3A5;
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(negedge core_clk_i);
		t_reset();
		t_modes();
		t_pairs();
		t_reference();
		t_forced();
		t_serial();
		give_verdict();
	end
endmodule : tb_acd_setup_decoder
